// ==== src/dpsw_device.sv ====
// Purpose: serial slave and wiper/comparator control of the dual digital_potentiometer
// Assumes: link logic clocked by scl, register file and write timer on pclk
// Notes: stored slots reset to a constant; no real nonvolatile array here
// Summary of operation
// - low address nibble must equal strap inputs
// - data changes only while clock low
// - start: data falls, clock high; await it
// - stop: data rises, clock high; ends transaction
// - host makes clock and starts every transfer
// - transmitter releases line; receiver acks ninth clock
// - acknowledge address, command, and data byte
// - data line driven low or released only
// - six-bit wiper decoded to one of sixty-four taps
// - wiper loads from host or stored slot
// - each channel owns wiper, control, stored slots
// - write protect low refuses nonvolatile writes
// - comparator output gated by its control bit
// - upper address nibble is fixed type id
// - command: opcode, register select, channel select
// - no address ack during nonvolatile write
`timescale 1ns/1ps
`default_nettype none
module dpsw_device import dpsw_pkg::*; #(
    parameter int WRITE_CYCLES = WR_CYCLES
) (
    input wire logic pclk,
    input wire logic presetn,
    dpsw_if.dev lk,
    input wire logic [3:0] address_strap_inputs,
    input wire logic write_protect_n,
    input wire logic [CH_N-1:0] cmp_raw,
    output logic comparator_output_zero,
    output logic comparator_output_one,
    output logic [TAP_N-1:0] tap_sel_zero,
    output logic [TAP_N-1:0] tap_sel_one,
    output logic nv_busy
);
    // data-line edge flops: only way to see start/stop without a free clock
    logic start_tgl_q;
    logic stop_tgl_q;

    always_ff @(negedge lk.sda or negedge presetn) begin
        if (!presetn) begin
            start_tgl_q <= 1'b0;
        end else if (lk.scl) begin
            start_tgl_q <= ~start_tgl_q;
        end
    end

    always_ff @(posedge lk.sda or negedge presetn) begin
        if (!presetn) begin
            stop_tgl_q <= 1'b0;
        end else if (lk.scl) begin
            stop_tgl_q <= ~stop_tgl_q;
        end
    end

    // link domain (scl)
    dpsw_lk_st_t st_q;
    logic [3:0] cnt_q;
    logic [6:0] sh_q;
    logic ack_q;
    logic [7:0] cmd_q;
    logic [POS_W-1:0] wdata_q;
    logic req_tgl_q;
    logic [7:0] rd_sh_q;
    logic start_seen_q;
    logic hold_s1_q;
    logic hold_s2_q;
    logic [3:0] strap_s1_q;
    logic [3:0] strap_s2_q;
    logic drive_q;
    // pclk flop, read here only through the two-stage sync below
    logic hold_q;
    logic lk_start;
    logic [7:0] byte_in;
    logic [3:0] cmd_op;
    logic [POS_W-1:0] rd_data_q;

    // start toggles while scl is high, so its setup to the next rising edge
    // is the start hold time; a single stage is all the link leaves room for
    assign lk_start = start_tgl_q != start_seen_q;
    assign byte_in = {sh_q, lk.sda};
    assign cmd_op = cmd_q[OP_LO +: 4];

    always_ff @(posedge lk.scl or negedge presetn) begin
        if (!presetn) begin
            start_seen_q <= 1'b0;
            hold_s1_q <= 1'b1;
            hold_s2_q <= 1'b1;
            strap_s1_q <= 4'h0;
            strap_s2_q <= 4'h0;
        end else begin
            start_seen_q <= start_tgl_q;
            hold_s1_q <= hold_q;
            hold_s2_q <= hold_s1_q;
            strap_s1_q <= address_strap_inputs;
            strap_s2_q <= strap_s1_q;
        end
    end

    // data is sampled on the rising clock edge, where it is stable
    always_ff @(posedge lk.scl or negedge presetn) begin
        if (!presetn) begin
            st_q <= LK_IDLE;
            cnt_q <= 4'h0;
            sh_q <= 7'h00;
            ack_q <= 1'b0;
            cmd_q <= 8'h00;
            wdata_q <= STORED_RESET;
            req_tgl_q <= 1'b0;
            rd_sh_q <= 8'h00;
        end else if (lk_start) begin
            st_q <= LK_ADDR;
            cnt_q <= 4'h1;
            sh_q <= {6'h00, lk.sda};
            ack_q <= 1'b0;
        end else begin
            unique case (st_q)
                LK_IDLE: begin
                    cnt_q <= 4'h0;
                end
                LK_RDATA: begin
                    if (cnt_q == BIT_ACK) begin
                        st_q <= LK_IDLE;
                        cnt_q <= 4'h0;
                    end else begin
                        rd_sh_q <= {rd_sh_q[6:0], 1'b0};
                        cnt_q <= cnt_q + 4'h1;
                    end
                end
                LK_ADDR, LK_CMD, LK_WDATA: begin
                    if (cnt_q == BIT_ACK) begin
                        cnt_q <= 4'h0;
                        if (st_q == LK_ADDR) begin
                            st_q <= ack_q ? LK_CMD : LK_IDLE;
                        end else if (st_q == LK_CMD && dpsw_is_read(cmd_op)) begin
                            st_q <= LK_RDATA;
                            rd_sh_q <= {2'b00, rd_data_q};
                        end else if (st_q == LK_CMD && dpsw_is_long(cmd_op)) begin
                            st_q <= LK_WDATA;
                        end else begin
                            st_q <= LK_IDLE;
                        end
                    end else begin
                        sh_q <= byte_in[6:0];
                        cnt_q <= cnt_q + 4'h1;
                        if (cnt_q == BIT_LAST) begin
                            if (st_q == LK_ADDR) begin
                                ack_q <= byte_in[7:4] == DEV_TYPE_ID
                                    && byte_in[3:0] == strap_s2_q
                                    && !hold_s2_q;
                            end else if (st_q == LK_CMD) begin
                                cmd_q <= byte_in;
                                ack_q <= 1'b1;
                                if (!dpsw_is_long(byte_in[OP_LO +: 4])
                                    || dpsw_is_read(byte_in[OP_LO +: 4])) begin
                                    req_tgl_q <= ~req_tgl_q;
                                end
                            end else begin
                                wdata_q <= byte_in[POS_W-1:0];
                                ack_q <= 1'b1;
                                req_tgl_q <= ~req_tgl_q;
                            end
                        end
                    end
                end
            endcase
        end
    end

    // line changes only after the falling clock edge
    always_ff @(negedge lk.scl or negedge presetn) begin
        if (!presetn) begin
            drive_q <= 1'b0;
        end else begin
            drive_q <= (st_q == LK_RDATA && cnt_q != BIT_ACK && !rd_sh_q[7])
                || (st_q != LK_RDATA && st_q != LK_IDLE && cnt_q == BIT_ACK && ack_q);
        end
    end

    assign lk.dev_sda_o = 1'b0;
    assign lk.dev_sda_oe = drive_q;

    // register domain (pclk)
    logic req_s1_q, req_s2_q, req_s3_q;
    logic stop_s1_q, stop_s2_q, stop_s3_q;
    logic wp_s1_q, wp_s2_q;
    logic [CH_N-1:0] cmp_s1_q, cmp_s2_q;
    logic [POS_W-1:0] live_q [TGT_N];
    logic [POS_W-1:0] stored_q [TGT_N][SLOT_N];
    logic boot_q;
    logic nv_pend_q;
    logic [BUSY_W-1:0] busy_q;
    logic req_ev;
    logic stop_ev;
    logic [1:0] p_sel;
    logic [1:0] r_sel;
    logic nv_op;

    assign req_ev = req_s2_q ^ req_s3_q;
    assign stop_ev = stop_s2_q ^ stop_s3_q;
    assign p_sel = cmd_q[PSEL_LO +: 2];
    assign r_sel = cmd_q[RSEL_LO +: 2];
    assign nv_op = (cmd_op == OP_WR_STORED) || (cmd_op == OP_SAVE);

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            {req_s1_q, req_s2_q, req_s3_q} <= 3'h0;
            {stop_s1_q, stop_s2_q, stop_s3_q} <= 3'h0;
            {wp_s1_q, wp_s2_q} <= 2'h0;
            cmp_s1_q <= '0;
            cmp_s2_q <= '0;
        end else begin
            {req_s1_q, req_s2_q, req_s3_q} <= {req_tgl_q, req_s1_q, req_s2_q};
            {stop_s1_q, stop_s2_q, stop_s3_q} <= {stop_tgl_q, stop_s1_q, stop_s2_q};
            {wp_s1_q, wp_s2_q} <= {write_protect_n, wp_s1_q};
            cmp_s1_q <= cmp_raw;
            cmp_s2_q <= cmp_s1_q;
        end
    end

    // cmd_q and wdata_q hold still from the request toggle until the next frame
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            boot_q <= 1'b0;
            for (int k = 0; k < TGT_N; k++) begin
                live_q[k] <= STORED_RESET;
                for (int s = 0; s < SLOT_N; s++) begin
                    stored_q[k][s] <= STORED_RESET;
                end
            end
        end else if (!boot_q) begin
            boot_q <= 1'b1;
            for (int k = 0; k < TGT_N; k++) begin
                live_q[k] <= stored_q[k][0];
            end
        end else if (req_ev) begin
            unique case (cmd_op)
                OP_WR_LIVE: live_q[p_sel] <= wdata_q;
                OP_RECALL: live_q[p_sel] <= stored_q[p_sel][r_sel];
                OP_WR_STORED: begin
                    if (wp_s2_q && busy_q == '0) begin
                        stored_q[p_sel][r_sel] <= wdata_q;
                    end
                end
                OP_SAVE: begin
                    if (wp_s2_q && busy_q == '0) begin
                        stored_q[p_sel][r_sel] <= live_q[p_sel];
                    end
                end
                default: begin
                end
            endcase
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            rd_data_q <= STORED_RESET;
        end else if (req_ev) begin
            rd_data_q <= (cmd_op == OP_RD_LIVE) ? live_q[p_sel] : stored_q[p_sel][r_sel];
        end
    end

    // the write timer starts at stop, as the array would
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            nv_pend_q <= 1'b0;
            busy_q <= '0;
            hold_q <= 1'b1;
        end else begin
            hold_q <= !boot_q || busy_q != '0;
            if (busy_q != '0) begin
                busy_q <= busy_q - BUSY_W'(1);
            end else if (stop_ev && nv_pend_q) begin
                busy_q <= BUSY_W'(WRITE_CYCLES - 1);
            end
            if (req_ev && nv_op && wp_s2_q && busy_q == '0) begin
                nv_pend_q <= 1'b1;
            end else if (stop_ev) begin
                nv_pend_q <= 1'b0;
            end
        end
    end

    assign nv_busy = hold_q;

    logic [CH_N-1:0] held_q;
    logic [CH_N-1:0] cmp_q;
    logic [TAP_N-1:0] tap_q [CH_N];

    for (genvar c = 0; c < CH_N; c++) begin : g_ch
        logic [POS_W-1:0] cc;
        assign cc = live_q[CH_N + c];
        always_ff @(posedge pclk or negedge presetn) begin
            if (!presetn) begin
                held_q[c] <= 1'b0;
                cmp_q[c] <= 1'b0;
            end else begin
                if (!cc[CC_LATCH]) begin
                    held_q[c] <= cmp_s2_q[c];
                end
                cmp_q[c] <= cc[CC_EN] && !cc[CC_SHDN]
                    && (cc[CC_LATCH] ? held_q[c] : cmp_s2_q[c]);
            end
        end
        for (genvar t = 0; t < TAP_N; t++) begin : g_tap
            always_ff @(posedge pclk or negedge presetn) begin
                if (!presetn) begin
                    tap_q[c][t] <= POS_W'(t) == STORED_RESET;
                end else begin
                    tap_q[c][t] <= live_q[c] == POS_W'(t);
                end
            end
        end
    end

    assign comparator_output_zero = cmp_q[0];
    assign comparator_output_one = cmp_q[1];
    assign tap_sel_zero = tap_q[0];
    assign tap_sel_one = tap_q[1];
endmodule
`default_nettype wire

// ==== src/dpsw_pkg.sv ====
// Purpose: shared constants and types for the dual potentiometer serial link
// Assumes: byte frames on the two-wire link, four targets with four stored slots each
// Notes: the host controller's register map lives here too
package dpsw_pkg;
    localparam int CH_N = 2;
    localparam int TGT_N = 4;
    localparam int SLOT_N = 4;
    localparam int POS_W = 6;
    localparam int TAP_N = 64;
    // device type nibble; the value is arbitrary
    localparam logic [3:0] DEV_TYPE_ID = 4'h3;
    localparam logic [3:0] OP_RD_LIVE = 4'h9;
    localparam logic [3:0] OP_WR_LIVE = 4'ha;
    localparam logic [3:0] OP_RD_STORED = 4'hb;
    localparam logic [3:0] OP_WR_STORED = 4'hc;
    localparam logic [3:0] OP_RECALL = 4'hd;
    localparam logic [3:0] OP_SAVE = 4'he;
    localparam int OP_LO = 4;
    localparam int RSEL_LO = 2;
    localparam int PSEL_LO = 0;
    localparam logic [POS_W-1:0] STORED_RESET = 6'h00;
    localparam int CC_EN = 0;
    localparam int CC_LATCH = 1;
    localparam int CC_SHDN = 2;
    localparam logic [3:0] BIT_LAST = 4'h7;
    localparam logic [3:0] BIT_ACK = 4'h8;
    localparam int T_WR_US = 5000;
    localparam int PCLK_MHZ = 250;
    localparam int WR_CYCLES = T_WR_US * PCLK_MHZ;
    localparam int BUSY_W = 21;
    localparam logic [11:0] REG_CMD = 12'h000;
    localparam logic [11:0] REG_STATUS = 12'h004;
    localparam logic [11:0] REG_DIV = 12'h008;
    localparam int CMDF_BYTE_LO = 0;
    localparam int CMDF_DATA_LO = 8;
    localparam int CMDF_ADDR_LO = 16;
    localparam int ST_BUSY = 0;
    localparam int ST_NACK = 1;
    localparam int ST_DATA_LO = 8;
    localparam logic [15:0] DIV_RESET = 16'h0005;

    typedef enum logic [2:0] {LK_IDLE, LK_ADDR, LK_CMD, LK_WDATA, LK_RDATA} dpsw_lk_st_t;
    typedef enum logic [1:0] {H_IDLE, H_START, H_BIT, H_STOP} dpsw_hst_t;

    function automatic logic dpsw_is_read(input logic [3:0] op);
        return (op == OP_RD_LIVE) || (op == OP_RD_STORED);
    endfunction

    function automatic logic dpsw_is_long(input logic [3:0] op);
        return dpsw_is_read(op) || (op == OP_WR_LIVE) || (op == OP_WR_STORED);
    endfunction
endpackage

// ==== src/dpsw_if.sv ====
// Purpose: two-wire link between the potentiometer device and its host controller
// Assumes: open-drain data line with a pull-up, clock driven by the host only
// Notes: the line level is the wired-AND of both enabled drivers
`timescale 1ns/1ps
`default_nettype none
interface dpsw_if;
    logic scl;
    logic host_sda_o;
    logic host_sda_oe;
    logic dev_sda_o;
    logic dev_sda_oe;
    logic sda;

    assign sda = (host_sda_oe ? host_sda_o : 1'b1) & (dev_sda_oe ? dev_sda_o : 1'b1);

    modport host (output scl, output host_sda_o, output host_sda_oe, input sda);
    modport dev (input scl, output dev_sda_o, output dev_sda_oe, input sda);
endinterface
`default_nettype wire

// ==== src/dpsw_host.sv ====
// Purpose: APB-controlled two-wire master for the dual potentiometer device
// Assumes: scl made from pclk by a quarter-period divider
// Notes: one command per launch; busy commands writes are dropped
`timescale 1ns/1ps
`default_nettype none
module dpsw_host import dpsw_pkg::*; (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic [11:0] paddr,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    dpsw_if.host lk
);
    dpsw_hst_t st_q;
    logic [1:0] ph_q;
    logic [3:0] bit_q;
    logic [1:0] byte_q;
    logic [7:0] sh_q;
    logic scl_q;
    logic oe_q;
    logic ackok_q;
    logic nack_q;
    logic [POS_W-1:0] rdata_q;
    logic [15:0] div_q;
    logic [15:0] tcnt_q;
    logic [7:0] cmd_q;
    logic [POS_W-1:0] wdata_q;
    logic [3:0] addr_q;
    logic [31:0] prdata_q;
    logic sda_s1_q, sda_s2_q;
    logic acc, go, tick, mapped, rx_byte;
    logic [1:0] last_byte;

    assign acc = psel && penable;
    assign mapped = paddr == REG_CMD || paddr == REG_STATUS || paddr == REG_DIV;
    assign pready = 1'b1;
    assign pslverr = acc && !mapped;
    assign prdata = prdata_q;
    assign go = acc && pwrite && paddr == REG_CMD && st_q == H_IDLE;
    assign tick = div_q == 16'h0000 || tcnt_q >= div_q - 16'h0001;
    assign last_byte = dpsw_is_long(cmd_q[OP_LO +: 4]) ? 2'h2 : 2'h1;
    assign rx_byte = dpsw_is_read(cmd_q[OP_LO +: 4]) && byte_q == 2'h2;

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            prdata_q <= 32'h0000_0000;
            div_q <= DIV_RESET;
            cmd_q <= 8'h00;
            wdata_q <= STORED_RESET;
            addr_q <= 4'h0;
            sda_s1_q <= 1'b1;
            sda_s2_q <= 1'b1;
        end else begin
            sda_s1_q <= lk.sda;
            sda_s2_q <= sda_s1_q;
            if (psel && !penable) begin
                prdata_q <= 32'h0000_0000;
                if (paddr == REG_STATUS) begin
                    prdata_q[ST_BUSY] <= st_q != H_IDLE;
                    prdata_q[ST_NACK] <= nack_q;
                    prdata_q[ST_DATA_LO +: POS_W] <= rdata_q;
                end else if (paddr == REG_DIV) begin
                    prdata_q[15:0] <= div_q;
                end
            end
            if (acc && pwrite && paddr == REG_DIV) begin
                div_q <= pwdata[15:0];
            end
            if (go) begin
                cmd_q <= pwdata[CMDF_BYTE_LO +: 8];
                wdata_q <= pwdata[CMDF_DATA_LO +: POS_W];
                addr_q <= pwdata[CMDF_ADDR_LO +: 4];
            end
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            tcnt_q <= 16'h0000;
        end else if (go || tick) begin
            tcnt_q <= 16'h0000;
        end else begin
            tcnt_q <= tcnt_q + 16'h0001;
        end
    end

    // each bit is four ticks: set data, raise clock, sample, drop clock
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            st_q <= H_IDLE;
            ph_q <= 2'h0;
            bit_q <= 4'h0;
            byte_q <= 2'h0;
            sh_q <= 8'h00;
            scl_q <= 1'b1;
            oe_q <= 1'b0;
            ackok_q <= 1'b0;
            nack_q <= 1'b0;
            rdata_q <= STORED_RESET;
        end else if (go) begin
            st_q <= H_START;
            ph_q <= 2'h0;
            nack_q <= 1'b0;
        end else if (tick && st_q != H_IDLE) begin
            ph_q <= ph_q + 2'h1;
            unique case (st_q)
                H_START: begin
                    if (ph_q == 2'h1) begin
                        oe_q <= 1'b1;
                    end else if (ph_q == 2'h2) begin
                        scl_q <= 1'b0;
                        sh_q <= {DEV_TYPE_ID, addr_q};
                        bit_q <= 4'h0;
                        byte_q <= 2'h0;
                        ph_q <= 2'h0;
                        st_q <= H_BIT;
                    end
                end
                H_BIT: begin
                    if (ph_q == 2'h0) begin
                        if (bit_q == BIT_ACK) begin
                            oe_q <= rx_byte;
                        end else begin
                            oe_q <= !rx_byte && !sh_q[7];
                        end
                    end else if (ph_q == 2'h1) begin
                        scl_q <= 1'b1;
                    end else if (ph_q == 2'h2) begin
                        if (bit_q == BIT_ACK) begin
                            ackok_q <= !sda_s2_q;
                        end else begin
                            sh_q <= {sh_q[6:0], sda_s2_q};
                        end
                    end else begin
                        scl_q <= 1'b0;
                        if (bit_q != BIT_ACK) begin
                            bit_q <= bit_q + 4'h1;
                        end else if (rx_byte) begin
                            rdata_q <= sh_q[POS_W-1:0];
                            st_q <= H_STOP;
                        end else if (!ackok_q) begin
                            nack_q <= 1'b1;
                            st_q <= H_STOP;
                        end else if (byte_q == last_byte) begin
                            st_q <= H_STOP;
                        end else begin
                            byte_q <= byte_q + 2'h1;
                            bit_q <= 4'h0;
                            sh_q <= (byte_q == 2'h0) ? cmd_q : {2'b00, wdata_q};
                        end
                    end
                end
                H_STOP: begin
                    if (ph_q == 2'h0) begin
                        oe_q <= 1'b1;
                    end else if (ph_q == 2'h1) begin
                        scl_q <= 1'b1;
                    end else if (ph_q == 2'h2) begin
                        oe_q <= 1'b0;
                    end else begin
                        st_q <= H_IDLE;
                    end
                end
                default: begin
                    st_q <= H_IDLE;
                end
            endcase
        end
    end

    assign lk.scl = scl_q;
    assign lk.host_sda_o = 1'b0;
    assign lk.host_sda_oe = oe_q;
endmodule
`default_nettype wire

// ==== test/dpsw_asserts.sv ====
// Purpose: wire-level checks on the potentiometer link
// Assumes: sampled on pclk; scl is made from pclk by the host
// Notes: [*8] windows hold because scl is far slower than pclk
`timescale 1ns/1ps
`default_nettype none
module dpsw_asserts (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic scl,
    input wire logic host_sda_o,
    input wire logic host_sda_oe,
    input wire logic dev_sda_o,
    input wire logic dev_sda_oe,
    input wire logic sda
);
    default clocking @(posedge pclk); endclocking
    default disable iff (!presetn);
    property p_dev_low; dev_sda_oe |-> !dev_sda_o; endproperty
    property p_host_low; host_sda_oe |-> !host_sda_o; endproperty
    property p_wire; sda == !(host_sda_oe || dev_sda_oe); endproperty
    property p_dev_chg; $changed(dev_sda_oe) |-> !scl; endproperty
    property p_ack; $rose(dev_sda_oe) |-> dev_sda_oe [*8]; endproperty
    // a zero read byte plus the command ack before it is nine scl periods of drive
    property p_rel; dev_sda_oe |-> ##[1:240] !dev_sda_oe; endproperty
    property p_stop; $rose(sda) && scl |=> !dev_sda_oe [*8]; endproperty
    property p_start; $fell(sda) && scl |=> !dev_sda_oe [*8]; endproperty
    a_dev_low: assert property (p_dev_low) else $error("dev drove high");
    a_host_low: assert property (p_host_low) else $error("host drove high");
    a_wire: assert property (p_wire) else $error("bad wired level");
    a_dev_chg: assert property (p_dev_chg) else $error("dev change, scl high");
    a_ack: assert property (p_ack) else $error("ack too short");
    a_rel: assert property (p_rel) else $error("line never released");
    a_stop: assert property (p_stop) else $error("drive after stop");
    a_start: assert property (p_start) else $error("drive after start");
    c_start: cover property ($fell(sda) && scl);
    c_stop: cover property ($rose(sda) && scl);
    c_ack: cover property ($rose(dev_sda_oe));
endmodule
`default_nettype wire

// ==== test/tb.sv ====
// Purpose: bench with the host driving the device over the link
// Assumes: divider at reset value, short nonvolatile write time
// Notes: expectations come from the command encoding only
`timescale 1ns/1ps
`default_nettype none
module tb import dpsw_pkg::*; ();
    localparam int WCYC = 200;
    // reset starts unknown so its fall fires every asynchronous reset, scl side too
    logic presetn;
    logic pclk = 0, psel = 0, penable = 0, pwrite = 0, wp_n = 1;
    logic pready, pslverr, perr, co0, co1, busy;
    logic [11:0] paddr = '0;
    logic [31:0] pwdata = '0, prdata, rd;
    logic [3:0] strap = 4'ha;
    logic [1:0] cmp = 2'b00;
    logic [TAP_N-1:0] t0, t1;
    // {channel select, value}
    logic [7:0] rows [6] = '{8'h00, 8'h7f, 8'h2a, 8'h55, 8'h81, 8'hc4};
    int fails = 0, n_checks = 0, cyc = 0;
    always #2 pclk = ~pclk;
    dpsw_if u_dpsw_if ();
    dpsw_host u_dpsw_host (.pclk(pclk), .presetn(presetn), .paddr(paddr), .psel(psel),
        .penable(penable), .pwrite(pwrite), .pwdata(pwdata), .prdata(prdata),
        .pready(pready), .pslverr(pslverr), .lk(u_dpsw_if.host));
    dpsw_device #(.WRITE_CYCLES(WCYC)) u_dpsw_device (.pclk(pclk), .presetn(presetn),
        .lk(u_dpsw_if.dev), .address_strap_inputs(strap), .write_protect_n(wp_n),
        .cmp_raw(cmp), .comparator_output_zero(co0), .comparator_output_one(co1),
        .tap_sel_zero(t0), .tap_sel_one(t1), .nv_busy(busy));
    dpsw_asserts u_dpsw_asserts (.pclk(pclk), .presetn(presetn), .scl(u_dpsw_if.scl),
        .host_sda_o(u_dpsw_if.host_sda_o), .host_sda_oe(u_dpsw_if.host_sda_oe),
        .dev_sda_o(u_dpsw_if.dev_sda_o), .dev_sda_oe(u_dpsw_if.dev_sda_oe),
        .sda(u_dpsw_if.sda));
    task automatic stop_test();
        $display("checks %0d mismatches %0d", n_checks, fails);
        if (fails == 0 && n_checks > 0) begin
            $display("RESULT: PASS");
        end else begin
            $display("RESULT: FAIL");
        end
        $finish;
    endtask
    task automatic chk(input logic [63:0] seen, input logic [63:0] exp);
        n_checks++;
        if (seen !== exp) begin
            fails++;
            $display("CHECK FAILED %0t seen %h expected %h", $time, seen, exp);
        end
    endtask
    task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
        @(posedge pclk);
        psel <= 1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1;
        @(posedge pclk);
        while (pready !== 1'b1) @(posedge pclk);
        rd = prdata;
        perr = pslverr;
        psel <= 0;
        penable <= 0;
    endtask
    // leaves the final status word in rd
    task automatic xfer(input logic [3:0] a, input logic [7:0] c, input logic [5:0] d);
        apb(1, REG_CMD, {12'h000, a, 2'b00, d, c});
        apb(0, REG_STATUS, 0);
        while (rd[ST_BUSY] !== 1'b0) apb(0, REG_STATUS, 0);
    endtask
    // a few edges first: the timer only starts once the stop has crossed over
    task automatic nvwait();
        repeat (4) @(posedge pclk);
        while (busy !== 1'b0) @(posedge pclk);
    endtask
    always @(posedge pclk) begin
        cyc++;
        if (cyc == 60000) begin
            fails++;
            stop_test();
        end
    end
    initial begin
        presetn <= 1'b0;
        repeat (20) @(posedge pclk);
        presetn <= 1;
        nvwait();
        chk(t0, 64'h1);
        chk(t1, 64'h1);
        foreach (rows[i]) begin
            xfer(strap, {OP_WR_LIVE, 2'b00, rows[i][7:6]}, rows[i][5:0]);
            chk(rd[ST_NACK], 0);
            xfer(strap, {OP_RD_LIVE, 2'b00, rows[i][7:6]}, 0);
            chk(rd[13:8], rows[i][5:0]);
            if (!rows[i][7]) chk(rows[i][6] ? t1 : t0, 64'h1 << rows[i][5:0]);
        end
        cmp <= 2'b11;
        repeat (4) @(posedge pclk);
        chk(co0, 1);
        chk(co1, 0);
        xfer(strap, {OP_WR_LIVE, 4'h2}, 6'h00);
        chk(co0, 0);
        xfer(strap, {OP_WR_LIVE, 4'h2}, 6'h03);
        cmp <= 2'b00;
        repeat (4) @(posedge pclk);
        chk(co0, 1);
        xfer(4'h5, {OP_RD_LIVE, 4'h0}, 0);
        chk(rd[ST_NACK], 1);
        xfer(strap, {OP_RD_LIVE, 4'h0}, 0);
        chk(rd[ST_NACK], 0);
        chk(rd[13:8], 6'h2a);
        wp_n <= 0;
        xfer(strap, {OP_WR_STORED, 4'h8}, 6'h11);
        chk(busy, 0);
        nvwait();
        xfer(strap, {OP_RD_STORED, 4'h8}, 0);
        chk(rd[13:8], STORED_RESET);
        wp_n <= 1;
        xfer(strap, {OP_WR_STORED, 4'h8}, 6'h11);
        chk(busy, 1);
        xfer(strap, {OP_RD_STORED, 4'h8}, 0);
        chk(rd[ST_NACK], 1);
        nvwait();
        xfer(strap, {OP_RD_STORED, 4'h8}, 0);
        chk(rd[13:8], 6'h11);
        xfer(strap, {OP_RECALL, 4'h8}, 0);
        chk(t0, 64'h1 << 17);
        xfer(strap, {OP_SAVE, 4'hd}, 0);
        nvwait();
        xfer(strap, {OP_RD_STORED, 4'hd}, 0);
        chk(rd[13:8], 6'h15);
        apb(0, 12'h00c, 0);
        chk(perr, 1);
        stop_test();
    end
endmodule
`default_nettype wire
